/* logic/dlsb_defines.svh */
`ifndef DLSB_DEFINES_SVH
`define DLSB_DEFINES_SVH

// Register byte offsets on the APB
`define DL_ENABLE_OFFSET   12'h000
`define DL_STATUS_OFFSET   12'h004
`define SB_STATUS_OFFSET   12'h008
`define SB_MASK_OFFSET     12'h00C

// Data link enable and status bit positions
`define DL_FCS_BIT         2
`define DL_ABORT_BIT       1
`define DL_IDLE_BIT        0

// Slip buffer status bit positions
`define SB_TX_FULL_BIT     7
`define SB_TX_EMPTY_BIT    6
`define SB_TX_SLIP_BIT     5
`define SB_LOOP_LOCK_BIT   4
`define SB_MF_LOCK_BIT     3
`define SB_RX_FULL_BIT     2

// Reset values
`define DL_ENABLE_RESET    3'h0
`define SB_MASK_RESET      4'h0
`define FLAGS_RESET        1'b0

`endif

/* logic/dlsb_pkg.sv */
package dlsb_pkg;

	// Receive data link events, one-cycle pulses from the HDLC receiver
	typedef struct packed {
		logic fcs_error;
		logic rx_abort;
		logic rx_idle;
	} dl_events_t;

	// Transmit and receive slip buffer activity
	typedef struct packed {
		logic tx_write;
		logic tx_read;
		logic tx_full;
		logic tx_empty;
		logic rx_write;
		logic rx_full;
	} slip_activity_t;

	// APB slave phase, Gray coded
	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_ACCESS = 2'b01
	} apb_phase_t;

endpackage

/* logic/sticky_flag_bank.sv */
`timescale 1ns/1ps
`include "dlsb_defines.svh"

module sticky_flag_bank #(
	parameter int WIDTH = 4
) (
	input  wire logic             i_clock, // Core clock
	input  wire logic             i_rstn,  // Sync reset, active low
	input  wire logic [WIDTH-1:0] i_set,   // Event pulses
	input  wire logic [WIDTH-1:0] i_clear, // Clear strobes
	output logic      [WIDTH-1:0] o_flags  // Sticky flags
);

	logic [WIDTH-1:0] flags_d;

	// Set wins over clear so no event is lost
	assign flags_d = (o_flags & ~i_clear) | i_set;

	// Flag storage
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_flags <= {WIDTH{`FLAGS_RESET}};
		end else begin
			o_flags <= flags_d;
		end
	end

endmodule

/* logic/datalink_and_slip_irq_regs.sv */
// What this block does
// - Frame check error raises the interrupt only while its enable is set.
// - Abort sequence, seven ones, interrupts only while its enable is set.
// - Idle flag octet 0x7E interrupts only while its enable is set.
// - Transmit write into full buffer drops a frame, sets bit 7.
// - Transmit read from empty buffer repeats a frame, sets bit 6.
// - Either transmit slip sets the slip flag, bit 5.
// - Slip flags hold until status is read, then clear.
// - Bit 4 shows loop carrier frame lock, read only.
// - Bit 3 shows multiframe lock, read only.
// - Receive write into full buffer drops a frame, sets full flag.
// - Receive full flag sits at bit 2 of slip status.
`timescale 1ns/1ps
`include "dlsb_defines.svh"

module datalink_and_slip_irq_regs
	import dlsb_pkg::*;
(
	input  wire logic           i_clock,      // 200 MHz core clock
	input  wire logic           i_rstn,       // Sync reset, active low
	input  wire logic           i_psel,       // APB select
	input  wire logic           i_penable,    // APB enable
	input  wire logic           i_pwrite,     // APB direction
	input  wire logic [11:0]    i_paddr,      // APB byte address
	input  wire logic [31:0]    i_pwdata,     // APB write data
	output logic      [31:0]    o_prdata,     // APB read data
	output logic                o_pready,     // APB ready
	output logic                o_pslverr,    // APB error, unmapped
	input  wire dl_events_t     i_dl_events,  // HDLC receiver events
	input  wire slip_activity_t i_slip,       // Slip buffer activity
	input  wire logic           i_loop_carrier_frame_lock, // Lock level
	input  wire logic           i_multiframe_lock,         // Lock level
	output logic                o_tx_drop_frame,   // Delete one frame
	output logic                o_tx_repeat_frame, // Repeat one frame
	output logic                o_rx_drop_frame,   // Delete one frame
	output logic                o_irq              // Level interrupt
);

	// Address decode shared by read mux and error check
	function automatic logic reg_hit(input logic [11:0] addr,
		input logic [11:0] off);
		reg_hit = (addr == off);
	endfunction

	apb_phase_t  phase_q;
	apb_phase_t  phase_d;
	logic [2:0]  dl_enable_q;
	logic [3:0]  sb_mask_q;
	logic [2:0]  dl_flags;
	logic [3:0]  sb_flags;
	logic [31:0] rd_word;
	logic        irq_d;

	// Transfer qualifiers
	wire setup     = i_psel && !i_penable;
	wire xfer_done = i_psel && i_penable && o_pready;
	wire wr_done   = xfer_done && i_pwrite;
	wire rd_done   = xfer_done && !i_pwrite;
	wire hit_en    = reg_hit(i_paddr, `DL_ENABLE_OFFSET);
	wire hit_dls   = reg_hit(i_paddr, `DL_STATUS_OFFSET);
	wire hit_sbs   = reg_hit(i_paddr, `SB_STATUS_OFFSET);
	wire hit_mask  = reg_hit(i_paddr, `SB_MASK_OFFSET);
	wire mapped    = hit_en || hit_dls || hit_sbs || hit_mask;
	wire wr_en     = wr_done && hit_en && !o_pslverr;
	wire wr_mask   = wr_done && hit_mask && !o_pslverr;
	wire wr_dls    = wr_done && hit_dls && !o_pslverr;
	wire rd_sbs    = rd_done && hit_sbs && !o_pslverr;

	// Slip events, combined from buffer full and empty flags and access strobes
	wire tx_full_evt  = i_slip.tx_write && i_slip.tx_full;
	wire tx_empty_evt = i_slip.tx_read && i_slip.tx_empty;
	wire tx_slip_evt  = tx_full_evt || tx_empty_evt;
	wire rx_full_evt  = i_slip.rx_write && i_slip.rx_full;

	// Data link flags: set by events, cleared by write one
	wire [2:0] dl_set = {i_dl_events.fcs_error, i_dl_events.rx_abort,
		i_dl_events.rx_idle};
	wire [2:0] dl_clr = wr_dls ? {i_pwdata[`DL_FCS_BIT],
		i_pwdata[`DL_ABORT_BIT], i_pwdata[`DL_IDLE_BIT]} : 3'h0;

	// Slip flags clear on read, only the bits the read actually showed,
	// so an event landing between setup and access is kept
	wire [3:0] sb_set = {tx_full_evt, tx_empty_evt, tx_slip_evt,
		rx_full_evt};
	wire [3:0] sb_clr = rd_sbs ? {o_prdata[`SB_TX_FULL_BIT],
		o_prdata[`SB_TX_EMPTY_BIT], o_prdata[`SB_TX_SLIP_BIT],
		o_prdata[`SB_RX_FULL_BIT]} : 4'h0;

	sticky_flag_bank #(
		.WIDTH (3)
	) u_dl_flags (
		.i_clock (i_clock),
		.i_rstn  (i_rstn),
		.i_set   (dl_set),
		.i_clear (dl_clr),
		.o_flags (dl_flags)
	);

	sticky_flag_bank #(
		.WIDTH (4)
	) u_sb_flags (
		.i_clock (i_clock),
		.i_rstn  (i_rstn),
		.i_set   (sb_set),
		.i_clear (sb_clr),
		.o_flags (sb_flags)
	);

	// Interrupt gating by enables and slip mask
	wire dl_pending = |(dl_flags & dl_enable_q);
	wire sb_pending = |(sb_flags & sb_mask_q);
	assign irq_d = dl_pending || sb_pending;

	// Read mux, captured in setup so prdata is a flop
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_en) begin
			rd_word[`DL_FCS_BIT]   = dl_enable_q[2];
			rd_word[`DL_ABORT_BIT] = dl_enable_q[1];
			rd_word[`DL_IDLE_BIT]  = dl_enable_q[0];
		end else if (hit_dls) begin
			rd_word[`DL_FCS_BIT]   = dl_flags[2];
			rd_word[`DL_ABORT_BIT] = dl_flags[1];
			rd_word[`DL_IDLE_BIT]  = dl_flags[0];
		end else if (hit_sbs) begin
			rd_word[`SB_TX_FULL_BIT]   = sb_flags[3];
			rd_word[`SB_TX_EMPTY_BIT]  = sb_flags[2];
			rd_word[`SB_TX_SLIP_BIT]   = sb_flags[1];
			rd_word[`SB_LOOP_LOCK_BIT] = i_loop_carrier_frame_lock;
			rd_word[`SB_MF_LOCK_BIT]   = i_multiframe_lock;
			rd_word[`SB_RX_FULL_BIT]   = sb_flags[0];
		end else if (hit_mask) begin
			rd_word[`SB_TX_FULL_BIT]  = sb_mask_q[3];
			rd_word[`SB_TX_EMPTY_BIT] = sb_mask_q[2];
			rd_word[`SB_TX_SLIP_BIT]  = sb_mask_q[1];
			rd_word[`SB_RX_FULL_BIT]  = sb_mask_q[0];
		end
	end

	// Phase: one wait-free access cycle after every setup
	always_comb begin
		case (phase_q)
			PH_IDLE:   phase_d = setup ? PH_ACCESS : PH_IDLE;
			PH_ACCESS: phase_d = setup ? PH_ACCESS : PH_IDLE;
			default:   phase_d = PH_IDLE;
		endcase
	end

	// APB answer flops
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			phase_q   <= PH_IDLE;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			phase_q   <= phase_d;
			o_pready  <= setup;
			o_pslverr <= setup && !mapped;
			o_prdata  <= (setup && !i_pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	// Software control registers
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			dl_enable_q <= `DL_ENABLE_RESET;
			sb_mask_q   <= `SB_MASK_RESET;
		end else begin
			if (wr_en) begin
				dl_enable_q <= {i_pwdata[`DL_FCS_BIT],
					i_pwdata[`DL_ABORT_BIT], i_pwdata[`DL_IDLE_BIT]};
			end
			if (wr_mask) begin
				sb_mask_q <= {i_pwdata[`SB_TX_FULL_BIT],
					i_pwdata[`SB_TX_EMPTY_BIT], i_pwdata[`SB_TX_SLIP_BIT],
					i_pwdata[`SB_RX_FULL_BIT]};
			end
		end
	end

	// Frame slip commands to the buffers and the interrupt line;
	// interrupt lags the flag by one cycle to stay a clean flop
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_tx_drop_frame   <= 1'b0;
			o_tx_repeat_frame <= 1'b0;
			o_rx_drop_frame   <= 1'b0;
			o_irq             <= 1'b0;
		end else begin
			o_tx_drop_frame   <= tx_full_evt;
			o_tx_repeat_frame <= tx_empty_evt;
			o_rx_drop_frame   <= rx_full_evt;
			o_irq             <= irq_d;
		end
	end

	// Checks on the block's own flags and outputs
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);

	a_fcs_irq_raise: assert property (
		(i_dl_events.fcs_error && dl_enable_q[2] && !wr_en)
		|-> ##2 o_irq)
		else $error("fcs error did not raise interrupt");

	a_abort_irq_gate: assert property (
		(dl_flags == 3'h2 && !dl_enable_q[1] && !sb_pending)
		|=> !o_irq)
		else $error("abort flag raised interrupt while disabled");

	a_idle_flag_set: assert property (
		i_dl_events.rx_idle |=> dl_flags[0] ##1 (o_irq || !$past(dl_enable_q[0])))
		else $error("idle event not recorded or not signalled");

	a_tx_full_drop: assert property (
		tx_full_evt |=> (o_tx_drop_frame && sb_flags[3] && sb_flags[1]))
		else $error("tx full write did not drop frame and flag");

	a_tx_empty_rep: assert property (
		tx_empty_evt |=> (o_tx_repeat_frame && sb_flags[2]))
		else $error("tx empty read did not repeat frame and flag");

	a_tx_slip_cause: assert property (
		$rose(sb_flags[1]) |-> $past(tx_full_evt || tx_empty_evt))
		else $error("tx slip flag rose without a slip");

	a_sb_clear_read: assert property (
		(rd_sbs && o_prdata[`SB_TX_FULL_BIT] && !tx_full_evt)
		|=> !sb_flags[3])
		else $error("tx full flag not cleared by read");

	a_sb_flag_hold: assert property (
		(sb_flags[0] && !rd_sbs) |=> sb_flags[0])
		else $error("rx full flag dropped without a read");

	a_loop_lock_read: assert property (
		(setup && !i_pwrite && hit_sbs)
		|=> o_prdata[`SB_LOOP_LOCK_BIT] == $past(i_loop_carrier_frame_lock))
		else $error("loop carrier lock bit misreported");

	a_mf_lock_read: assert property (
		(setup && !i_pwrite && hit_sbs)
		|=> o_prdata[`SB_MF_LOCK_BIT] == $past(i_multiframe_lock))
		else $error("multiframe lock bit misreported");

	a_rx_full_bit2: assert property (
		(rx_full_evt ##1 (setup && !i_pwrite && hit_sbs))
		|=> (o_prdata[`SB_RX_FULL_BIT]
			&& o_rx_drop_frame == $past(rx_full_evt)))
		else $error("rx full flag not shown at bit 2");

	a_enable_reset: assert property (disable iff (1'b0)
		!i_rstn |=> (dl_enable_q == 3'h0 && !o_irq))
		else $error("enables not cleared by reset");

	c_fcs_irq: cover property (
		i_dl_events.fcs_error && dl_enable_q[2] ##2 o_irq);
	c_tx_slip_read: cover property (tx_slip_evt ##[1:20] rd_sbs);
	c_unmapped: cover property (xfer_done && o_pslverr);

endmodule

/* dv/datalink_and_slip_irq_regs_tb_top.sv */
`timescale 1ns/1ps
`include "dlsb_defines.svh"

module datalink_and_slip_irq_regs_tb_top
	import dlsb_pkg::*;
;
	logic           clock;
	logic           rstn;
	logic           psel;
	logic           penable;
	logic           pwrite;
	logic [11:0]    paddr;
	logic [31:0]    pwdata;
	logic [31:0]    o_prdata;
	logic           o_pready;
	logic           o_pslverr;
	dl_events_t     dl;
	slip_activity_t slip;
	logic           loop_lock;
	logic           mf_lock;
	logic           o_tx_drop_frame;
	logic           o_tx_repeat_frame;
	logic           o_rx_drop_frame;
	logic           o_irq;
	int             err_count = 0;
	int             checked = 0;
	int             cycles = 0;
	logic [15:0]    lfsr = 16'hBC09;

	datalink_and_slip_irq_regs i_dut (
		.i_clock                   (clock),
		.i_rstn                    (rstn),
		.i_psel                    (psel),
		.i_penable                 (penable),
		.i_pwrite                  (pwrite),
		.i_paddr                   (paddr),
		.i_pwdata                  (pwdata),
		.o_prdata                  (o_prdata),
		.o_pready                  (o_pready),
		.o_pslverr                 (o_pslverr),
		.i_dl_events               (dl),
		.i_slip                    (slip),
		.i_loop_carrier_frame_lock (loop_lock),
		.i_multiframe_lock         (mf_lock),
		.o_tx_drop_frame           (o_tx_drop_frame),
		.o_tx_repeat_frame         (o_tx_repeat_frame),
		.o_rx_drop_frame           (o_rx_drop_frame),
		.o_irq                     (o_irq)
	);

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Expected slip status byte for one cycle of buffer activity
	function automatic logic [7:0] slip_flags(input logic [5:0] s);
		slip_activity_t a;
		a = s;
		slip_flags = 8'h00;
		if (a.tx_write && a.tx_full) slip_flags |= 8'hA0;
		if (a.tx_read && a.tx_empty) slip_flags |= 8'h60;
		if (a.rx_write && a.rx_full) slip_flags |= 8'h04;
	endfunction

	function automatic logic [2:0] slip_pulses(input logic [5:0] s);
		slip_activity_t a;
		a = s;
		return {a.tx_write & a.tx_full, a.tx_read & a.tx_empty,
			a.rx_write & a.rx_full};
	endfunction

	task automatic report_and_stop();
		if (err_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; waits for pready, never assumes the latency
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		rd = o_prdata;
		err = o_pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk(32'h0, 32'h1, "no pready");
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
		input string what);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp, what);
	endtask

	// Events high for one cycle; returns pulses seen one edge later
	task automatic fire(input logic [2:0] ev, input logic [5:0] sl,
		output logic [2:0] p);
		@(posedge clock);
		dl <= ev;
		slip <= sl;
		@(posedge clock);
		dl <= 3'h0;
		slip <= 6'h00;
		#1 p = {o_tx_drop_frame, o_tx_repeat_frame, o_rx_drop_frame};
		@(posedge clock);
		#1;
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			$display("MISMATCH t=%0t timeout", $time);
			report_and_stop();
		end
	end

	initial begin
		logic [31:0] d;
		logic        e;
		logic [2:0]  en;
		logic [2:0]  ev;
		logic [2:0]  p;
		logic [5:0]  corner [4];
		logic [5:0]  kinds [5];
		corner = '{6'h24, 6'h12, 6'h09, 6'h07};
		kinds = '{6'h28, 6'h14, 6'h03, 6'h20, 6'h3C};
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		dl = 3'h0;
		slip = 6'h00;
		loop_lock = 1'b0;
		mf_lock = 1'b0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		rd_chk(`DL_ENABLE_OFFSET, 32'h0, "enable reset");
		rd_chk(`SB_MASK_OFFSET, 32'h0, "mask reset");
		rd_chk(`SB_STATUS_OFFSET, 32'h0, "slip reset");
		apb(1'b0, 12'h010, 32'h0, d, e);
		chk(e, 1'b1, "unmapped err");
		chk(d, 32'h0, "unmapped data");
		// Data link events: single-bit corners, all-disabled, then random
		for (int i = 0; i < 12; i++) begin
			lfsr = lfsr_next(lfsr);
			{en, ev} = (i < 4) ? corner[i] : lfsr[5:0];
			wr(`DL_ENABLE_OFFSET, {lfsr, 13'h0, en});
			rd_chk(`DL_ENABLE_OFFSET, {29'h0, en}, "enable rw");
			fire(ev, 6'h00, p);
			chk(o_irq, |(en & ev), "dl irq");
			rd_chk(`DL_STATUS_OFFSET, {29'h0, ev}, "dl status");
			wr(`DL_STATUS_OFFSET, 32'h7);
			repeat (2) @(posedge clock);
			#1 chk(o_irq, 1'b0, "dl irq clear");
		end
		// Slip events, first masked off, then unmasked
		for (int m = 0; m < 2; m++) begin
			wr(`SB_MASK_OFFSET, m ? 32'hE4 : 32'h0);
			rd_chk(`SB_MASK_OFFSET, m ? 32'hE4 : 32'h0, "mask rw");
			foreach (kinds[k]) begin
				fire(3'h0, kinds[k], p);
				chk(p, slip_pulses(kinds[k]), "slip pulse");
				chk(o_irq, m && slip_flags(kinds[k]) != 0, "slip irq");
				repeat (4) @(posedge clock);
				// Software reads full and empty bits beside the slip bit
				rd_chk(`SB_STATUS_OFFSET, slip_flags(kinds[k]),
					"flags");
				rd_chk(`SB_STATUS_OFFSET, 32'h0, "read clears");
				chk(o_irq, 1'b0, "slip irq clear");
			end
		end
		// Lock levels pass straight through, unaffected by reads
		for (int i = 0; i < 4; i++) begin
			loop_lock <= i[1];
			mf_lock <= i[0];
			@(posedge clock);
			rd_chk(`SB_STATUS_OFFSET, {27'h0, i[1], i[0], 3'h0},
				"locks");
		end
		report_and_stop();
	end
endmodule
